// File: logic/spf_defines.svh
// register indices, field positions, reset values and sizes of the serial port fifo access block
`ifndef SPF_DEFINES_SVH
`define SPF_DEFINES_SVH

// data word and fifo geometry
`define SPF_WORD_W        32
`define SPF_HALF_W        16
`define SPF_FIFO_DEPTH    16
`define SPF_CNT_W         5
`define SPF_IDX_W         6

// register indices, byte address is four times the index
`define SPF_IDX_RX_UPPER  6'h00
`define SPF_IDX_RX_LOWER  6'h01
`define SPF_IDX_TX_UPPER  6'h02
`define SPF_IDX_TX_LOWER  6'h03
`define SPF_IDX_TX_CTRL   6'h20
`define SPF_IDX_RX_CTRL   6'h21
`define SPF_IDX_MODE      6'h30
`define SPF_IDX_STATUS    6'h31

// reset values
`define SPF_TX_CTRL_RESET 16'ha000
`define SPF_RX_CTRL_RESET 16'h201f

// mode register fields
`define SPF_MODE_FIFO     0
`define SPF_MODE_RX_FLUSH 1
`define SPF_MODE_TX_FLUSH 2

// status register fields
`define SPF_ST_RX_CNT_LO  0
`define SPF_ST_TX_CNT_LO  8
`define SPF_ST_RX_EMPTY   16
`define SPF_ST_TX_FULL    17
`define SPF_ST_STICKY_LO  18
`define SPF_ST_RX_HELD    22

// sticky flag positions inside the sticky group
`define SPF_STK_N         4
`define SPF_STK_RX_OVR    0
`define SPF_STK_TX_DROP   1
`define SPF_STK_RX_ORDER  2
`define SPF_STK_TX_ORDER  3

`endif

// File: logic/spf_pkg.sv
// types shared by the serial port fifo access block
package spf_pkg;

	// one serial data word as its two 16-bit halves
	typedef struct packed {
		logic [15:0] upper;
		logic [15:0] lower;
	} spf_word_t;

	// progress through the two halves of one word
	typedef enum logic {
		SPF_ORD_IDLE,
		SPF_ORD_UPPER_DONE
	} spf_order_t;

endpackage : spf_pkg

// File: logic/spf_fifo.sv
// synchronous fifo with array storage, flush and occupancy count
`include "spf_defines.svh"

module spf_fifo
#(
	parameter int WIDTH = `SPF_WORD_W,
	parameter int DEPTH = `SPF_FIFO_DEPTH
)
(
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	// control
	input  wire logic                     flush,
	input  wire logic                     push,
	input  wire logic [WIDTH-1:0]         push_data,
	input  wire logic                     pop,
	// state
	output logic      [WIDTH-1:0]         head,
	output logic      [$clog2(DEPTH):0]   count,
	output logic                          full,
	output logic                          empty
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic             do_push;
	logic             do_pop;

	// a push when full or a pop when empty leaves the pointers alone
	assign do_push = push && !full;
	assign do_pop  = pop && !empty;
	assign full    = count == (AW+1)'(DEPTH);
	assign empty   = count == '0;
	assign head    = mem[rd_ptr];

	// storage, no reset needed on the array
	always_ff @(posedge clk)
	begin
		if (do_push)
			mem[wr_ptr] <= push_data;
	end

	// pointers and count
	always_ff @(posedge clk)
	begin
		if (!rst_n || flush)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			if (do_push)
				wr_ptr <= wr_ptr + 1'b1;
			if (do_pop)
				rd_ptr <= rd_ptr + 1'b1;
			count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

endmodule : spf_fifo

// File: logic/spf_buf2.sv
// two-entry buffer with valid and ready on both sides
module spf_buf2
(
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	// filling side
	input  wire logic                in_valid,
	output logic                     in_ready,
	input  spf_pkg::spf_word_t       in_data,
	// draining side
	output logic                     out_valid,
	input  wire logic                out_ready,
	output spf_pkg::spf_word_t       out_data
);
	spf_pkg::spf_word_t slot1;
	logic [1:0]         used;
	logic               push;
	logic               pop;

	// handshakes
	assign in_ready  = used != 2'h2;
	assign out_valid = used != 2'h0;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// slot0 is the head, slot1 waits behind it
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			out_data <= '0;
			slot1    <= '0;
			used     <= 2'h0;
		end
		else
		begin
			if (pop && used == 2'h2)
				out_data <= slot1;
			else if (push && (used == 2'h0 || (pop && used == 2'h1)))
				out_data <= in_data;
			if (push && (used == 2'h2 || (!pop && used == 2'h1)))
				slot1 <= in_data;
			used <= used + 2'(push) - 2'(pop);
		end
	end

endmodule : spf_buf2

// File: logic/spf_fifo_access.sv
// serial port fifo access: wishbone slave, receive and transmit data windows, fifo control
`include "spf_defines.svh"

module spf_fifo_access
(
	// clock and reset
	input  wire logic                   REF_CLK,
	input  wire logic                   RST_N,
	// wishbone classic slave
	input  wire logic                   CYC_I,
	input  wire logic                   STB_I,
	input  wire logic                   WE_I,
	input  wire logic [7:0]             ADR_I,
	input  wire logic [3:0]             SEL_I,
	input  wire logic [31:0]            DAT_I,
	output logic      [31:0]            DAT_O,
	output logic                        ACK_O,
	// receive shifter side
	input  wire logic                   RX_VALID,
	input  spf_pkg::spf_word_t          RX_WORD,
	output logic                        RX_READY,
	// transmit shifter side
	output logic                        TX_VALID,
	output spf_pkg::spf_word_t          TX_WORD,
	input  wire logic                   TX_READY,
	// settings for the rest of the port
	output logic                        FIFO_MODE,
	output logic      [15:0]            TX_FIFO_CTRL,
	output logic      [15:0]            RX_FIFO_CTRL
);

	// byte lane merge of a 16-bit register
	function automatic logic [15:0] merge_half(
		input logic [15:0] old_v,
		input logic [15:0] wr_v,
		input logic [1:0]  lanes
	);
		merge_half = {lanes[1] ? wr_v[15:8] : old_v[15:8],
			lanes[0] ? wr_v[7:0] : old_v[7:0]};
	endfunction : merge_half

	// bus state
	logic                     ack;
	logic [31:0]              read_mux;
	logic                     take;
	logic                     take_rd;
	logic                     take_wr;
	logic [`SPF_IDX_W-1:0]    idx;
	logic                     hit_rx_upper;
	logic                     hit_rx_lower;
	logic                     hit_tx_upper;
	logic                     hit_tx_lower;
	logic                     hit_tx_ctrl;
	logic                     hit_rx_ctrl;
	logic                     hit_mode;
	logic                     hit_status;
	logic [15:0]              wr_half;

	// software registers
	logic                     fifo_mode;
	logic [15:0]              tx_ctrl;
	logic [15:0]              rx_ctrl;
	logic [15:0]              tx_upper_stage;
	spf_pkg::spf_word_t       rx_hold;
	logic                     rx_held;
	spf_pkg::spf_order_t      rx_order;
	spf_pkg::spf_order_t      next_rx_order;
	spf_pkg::spf_order_t      tx_order;
	spf_pkg::spf_order_t      next_tx_order;

	// fifo and buffer wiring
	logic                     mode_wr;
	logic                     rx_flush;
	logic                     tx_flush;
	logic                     rx_push;
	logic                     rx_pop;
	spf_pkg::spf_word_t       rx_head;
	logic [`SPF_CNT_W-1:0]    rx_count;
	logic                     rx_full;
	logic                     rx_empty;
	spf_pkg::spf_word_t       rx_view;
	logic                     tx_push;
	spf_pkg::spf_word_t       tx_push_word;
	logic                     tx_pop;
	spf_pkg::spf_word_t       tx_head;
	logic [`SPF_CNT_W-1:0]    tx_count;
	logic                     tx_full;
	logic                     tx_empty;
	logic                     buf_in_valid;
	logic                     buf_in_ready;
	spf_pkg::spf_word_t       buf_in_data;
	logic                     direct_valid;

	// sticky flags
	logic [`SPF_STK_N-1:0]    sticky;
	logic [`SPF_STK_N-1:0]    sticky_set;
	logic [`SPF_STK_N-1:0]    sticky_clr;

	// request decode, one request per ack
	assign take    = CYC_I && STB_I && !ack;
	assign take_rd = take && !WE_I;
	assign take_wr = take && WE_I;
	assign idx     = ADR_I[7:2];
	assign wr_half = DAT_I[15:0];

	// data windows keep their addresses in both modes
	assign hit_rx_upper = idx == `SPF_IDX_RX_UPPER;
	assign hit_rx_lower = idx == `SPF_IDX_RX_LOWER;
	assign hit_tx_upper = idx == `SPF_IDX_TX_UPPER;
	assign hit_tx_lower = idx == `SPF_IDX_TX_LOWER;
	// fifo control registers are only present in fifo mode
	assign hit_tx_ctrl  = fifo_mode && idx == `SPF_IDX_TX_CTRL;
	assign hit_rx_ctrl  = fifo_mode && idx == `SPF_IDX_RX_CTRL;
	assign hit_mode     = idx == `SPF_IDX_MODE;
	assign hit_status   = idx == `SPF_IDX_STATUS;

	// flushes come from the mode register or from a change of mode
	assign mode_wr  = take_wr && hit_mode && SEL_I[0];
	assign rx_flush = mode_wr && (DAT_I[`SPF_MODE_RX_FLUSH]
		|| DAT_I[`SPF_MODE_FIFO] != fifo_mode);
	assign tx_flush = mode_wr && (DAT_I[`SPF_MODE_TX_FLUSH]
		|| DAT_I[`SPF_MODE_FIFO] != fifo_mode);

	// receive side: fifo in fifo mode, single holding word otherwise
	assign rx_push  = fifo_mode && RX_VALID && !rx_full;
	assign RX_READY = fifo_mode ? !rx_full : 1'b1;
	assign rx_pop   = fifo_mode && take_rd && hit_rx_lower && !rx_empty;
	assign rx_view  = fifo_mode ? (rx_empty ? '0 : rx_head) : rx_hold;

	// transmit side: the lower half closes the word
	assign tx_push_word = '{upper: tx_upper_stage,
		lower: merge_half(16'h0000, wr_half, SEL_I[1:0])};
	assign tx_push      = fifo_mode && take_wr && hit_tx_lower && !tx_full;
	assign direct_valid = !fifo_mode && take_wr && hit_tx_lower;

	// the buffer feeds from the fifo head or from a direct write
	assign buf_in_valid = fifo_mode ? !tx_empty : direct_valid;
	assign buf_in_data  = fifo_mode ? tx_head : tx_push_word;
	assign tx_pop       = fifo_mode && !tx_empty && buf_in_ready;

	// events that set sticky flags
	assign sticky_set[`SPF_STK_RX_OVR]   = !fifo_mode && RX_VALID && rx_held
		&& !(take_rd && hit_rx_lower);
	assign sticky_set[`SPF_STK_TX_DROP]  = take_wr && hit_tx_lower
		&& (fifo_mode ? tx_full : !buf_in_ready);
	assign sticky_set[`SPF_STK_RX_ORDER] = take_rd && hit_rx_lower
		&& rx_order == spf_pkg::SPF_ORD_IDLE;
	assign sticky_set[`SPF_STK_TX_ORDER] = take_wr && hit_tx_lower
		&& tx_order == spf_pkg::SPF_ORD_IDLE;
	assign sticky_clr = (take_wr && hit_status && SEL_I[2])
		? DAT_I[`SPF_ST_STICKY_LO +: `SPF_STK_N] : '0;

	// sticky flags, a set in the clearing cycle wins
	genvar g;
	generate
		for (g = 0; g < `SPF_STK_N; g++)
		begin : g_sticky
			logic flag;
			always_ff @(posedge REF_CLK)
			begin
				if (!RST_N)
					flag <= 1'b0;
				else if (sticky_set[g])
					flag <= 1'b1;
				else if (sticky_clr[g])
					flag <= 1'b0;
			end
			assign sticky[g] = flag;
		end
	endgenerate

	// read data selection
	always_comb
	begin
		read_mux = 32'h0000_0000;
		if (hit_rx_upper)
			read_mux[15:0] = rx_view.upper;
		else if (hit_rx_lower)
			read_mux[15:0] = rx_view.lower;
		else if (hit_tx_ctrl)
			read_mux[15:0] = tx_ctrl;
		else if (hit_rx_ctrl)
			read_mux[15:0] = rx_ctrl;
		else if (hit_mode)
			read_mux[`SPF_MODE_FIFO] = fifo_mode;
		else if (hit_status)
		begin
			read_mux[`SPF_ST_RX_CNT_LO +: `SPF_CNT_W] = rx_count;
			read_mux[`SPF_ST_TX_CNT_LO +: `SPF_CNT_W] = tx_count;
			read_mux[`SPF_ST_RX_EMPTY] = rx_empty;
			read_mux[`SPF_ST_TX_FULL] = tx_full;
			read_mux[`SPF_ST_STICKY_LO +: `SPF_STK_N] = sticky;
			read_mux[`SPF_ST_RX_HELD] = rx_held;
		end
	end

	// bus answer one cycle after the request is taken
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
		begin
			ack   <= 1'b0;
			DAT_O <= 32'h0000_0000;
		end
		else
		begin
			ack <= take;
			if (take_rd)
				DAT_O <= read_mux;
		end
	end

	assign ACK_O = ack;

	// fifo control and mode registers
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
		begin
			tx_ctrl   <= `SPF_TX_CTRL_RESET;
			rx_ctrl   <= `SPF_RX_CTRL_RESET;
			fifo_mode <= 1'b0;
		end
		else
		begin
			if (take_wr && hit_tx_ctrl)
				tx_ctrl <= merge_half(tx_ctrl, wr_half, SEL_I[1:0]);
			if (take_wr && hit_rx_ctrl)
				rx_ctrl <= merge_half(rx_ctrl, wr_half, SEL_I[1:0]);
			if (mode_wr)
				fifo_mode <= DAT_I[`SPF_MODE_FIFO];
		end
	end

	assign FIFO_MODE    = fifo_mode;
	assign TX_FIFO_CTRL = tx_ctrl;
	assign RX_FIFO_CTRL = rx_ctrl;

	// upper transmit half waits here for its lower half
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
			tx_upper_stage <= 16'h0000;
		else if (take_wr && hit_tx_upper)
			tx_upper_stage <= merge_half(tx_upper_stage, wr_half, SEL_I[1:0]);
	end

	// holding word for operation without the fifo
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
		begin
			rx_hold <= '0;
			rx_held <= 1'b0;
		end
		else if (!fifo_mode && RX_VALID)
		begin
			rx_hold <= RX_WORD;
			rx_held <= 1'b1;
		end
		else if (take_rd && hit_rx_lower)
			rx_held <= 1'b0;
	end

	// order of half accesses on the receive window
	always_comb
	begin
		next_rx_order = rx_order;
		case (rx_order)
			spf_pkg::SPF_ORD_IDLE:
				if (take_rd && hit_rx_upper)
					next_rx_order = spf_pkg::SPF_ORD_UPPER_DONE;
			spf_pkg::SPF_ORD_UPPER_DONE:
				if (take_rd && hit_rx_lower)
					next_rx_order = spf_pkg::SPF_ORD_IDLE;
			default:
				next_rx_order = spf_pkg::SPF_ORD_IDLE;
		endcase
	end

	// order of half accesses on the transmit window
	always_comb
	begin
		next_tx_order = tx_order;
		case (tx_order)
			spf_pkg::SPF_ORD_IDLE:
				if (take_wr && hit_tx_upper)
					next_tx_order = spf_pkg::SPF_ORD_UPPER_DONE;
			spf_pkg::SPF_ORD_UPPER_DONE:
				if (take_wr && hit_tx_lower)
					next_tx_order = spf_pkg::SPF_ORD_IDLE;
			default:
				next_tx_order = spf_pkg::SPF_ORD_IDLE;
		endcase
	end

	// order state registers
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
		begin
			rx_order <= spf_pkg::SPF_ORD_IDLE;
			tx_order <= spf_pkg::SPF_ORD_IDLE;
		end
		else
		begin
			rx_order <= next_rx_order;
			tx_order <= next_tx_order;
		end
	end

	// receive fifo
	spf_fifo u_rx_fifo
	(
		.clk       (REF_CLK),
		.rst_n     (RST_N),
		.flush     (rx_flush),
		.push      (rx_push),
		.push_data (RX_WORD),
		.pop       (rx_pop),
		.head      (rx_head),
		.count     (rx_count),
		.full      (rx_full),
		.empty     (rx_empty)
	);

	// transmit fifo
	spf_fifo u_tx_fifo
	(
		.clk       (REF_CLK),
		.rst_n     (RST_N),
		.flush     (tx_flush),
		.push      (tx_push),
		.push_data (tx_push_word),
		.pop       (tx_pop),
		.head      (tx_head),
		.count     (tx_count),
		.full      (tx_full),
		.empty     (tx_empty)
	);

	// two-entry buffer toward the transmit shifter, a stall loses no word
	spf_buf2 u_tx_buf
	(
		.clk       (REF_CLK),
		.rst_n     (RST_N),
		.in_valid  (buf_in_valid),
		.in_ready  (buf_in_ready),
		.in_data   (buf_in_data),
		.out_valid (TX_VALID),
		.out_ready (TX_READY),
		.out_data  (TX_WORD)
	);

endmodule : spf_fifo_access

// File: verif/spf_fifo_access_properties.sv
// port assertions for the serial port fifo access block, with its bind
module spf_fifo_access_chk
(
	// clock and reset
	input  wire logic          REF_CLK,
	input  wire logic          RST_N,
	// register bus
	input  wire logic          CYC_I,
	input  wire logic          STB_I,
	input  wire logic          WE_I,
	input  wire logic [7:0]    ADR_I,
	input  wire logic [31:0]   DAT_O,
	input  wire logic          ACK_O,
	// streams
	input  wire logic          RX_READY,
	input  wire logic          TX_VALID,
	input  spf_pkg::spf_word_t TX_WORD,
	input  wire logic          TX_READY,
	// settings
	input  wire logic          FIFO_MODE,
	input  wire logic [15:0]   TX_FIFO_CTRL,
	input  wire logic [15:0]   RX_FIFO_CTRL
);
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);

	// taken requests and the register they aim at
	wire logic       take = CYC_I && STB_I && !ACK_O;
	wire logic       rd   = take && !WE_I;
	wire logic       wr   = take && WE_I;
	wire logic [5:0] idx  = ADR_I[7:2];

	chk_ack_pulse: assert property (ACK_O |=> !ACK_O)
		else $error("ack held longer than one cycle");
	chk_ack_answer: assert property (take |=> ACK_O)
		else $error("request not answered next cycle");
	chk_dat_hold: assert property (!$stable(DAT_O) |-> ACK_O && $past(rd))
		else $error("read data moved without a read");
	chk_ctrl_reset: assert property ($rose(RST_N) |->
		TX_FIFO_CTRL == 16'ha000 && RX_FIFO_CTRL == 16'h201f)
		else $error("fifo control reset value wrong");
	chk_tx_ctrl_wr: assert property (!$stable(TX_FIFO_CTRL) |->
		$past(wr && idx == 6'h20 && FIFO_MODE))
		else $error("tx fifo control changed without a write");
	chk_rx_ctrl_wr: assert property (!$stable(RX_FIFO_CTRL) |->
		$past(wr && idx == 6'h21 && FIFO_MODE))
		else $error("rx fifo control changed without a write");
	chk_plain_ready: assert property (!FIFO_MODE |-> RX_READY)
		else $error("receive refused outside fifo mode");
	chk_head_keep: assert property (
		FIFO_MODE && !RX_READY && rd && idx == 6'h00 |=> !RX_READY)
		else $error("upper read freed the receive fifo");
	chk_lower_pop: assert property (
		FIFO_MODE && !RX_READY && rd && idx == 6'h01 |=> RX_READY)
		else $error("lower read did not pop");
	chk_tx_stall: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_WORD))
		else $error("transmit word lost in a stall");

	// main scenarios
	cov_rx_pop: cover property (rd && idx == 6'h01 && FIFO_MODE);
	cov_tx_push: cover property (wr && idx == 6'h03 && FIFO_MODE);
	cov_tx_move: cover property (TX_VALID && TX_READY);
	cov_plain_rx: cover property (!FIFO_MODE && rd && idx == 6'h01);
endmodule : spf_fifo_access_chk

bind spf_fifo_access spf_fifo_access_chk u_spf_fifo_access_chk (.REF_CLK, .RST_N, .CYC_I,
	.STB_I, .WE_I, .ADR_I, .DAT_O, .ACK_O, .RX_READY, .TX_VALID, .TX_WORD, .TX_READY,
	.FIFO_MODE, .TX_FIFO_CTRL, .RX_FIFO_CTRL);

// File: verif/spf_shifter_model.sv
// behavioural receive and transmit shifters beside the fifo access block
module spf_shifter_model
(
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rst_n,
	// enables from the bench
	input  wire logic          rx_en,
	input  wire logic          tx_en,
	// receive shifter offers words
	output logic               rx_valid,
	output spf_pkg::spf_word_t rx_word,
	input  wire logic          rx_ready,
	// transmit shifter takes words
	input  wire logic          tx_valid,
	input  spf_pkg::spf_word_t tx_word,
	output logic               tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] rx_sent[$];
	logic [31:0] tx_got[$];
	integer      seed = 32'h38ba7e14;

	// quiet outputs at time zero
	initial
	begin
		rx_valid = 1'b0;
		rx_word = 32'h0;
		tx_ready = 1'b0;
	end

	// log handshakes, hold an offer until taken, idle data keeps toggling, stall at random
	always @(posedge clk)
	begin
		if (rx_valid && rx_ready)
			rx_sent.push_back(rx_word);
		if (tx_valid && tx_ready)
			tx_got.push_back(tx_word);
		if (!rst_n)
			rx_valid <= 1'b0;
		else if (!rx_valid || rx_ready)
		begin
			rx_valid <= rx_en;
			rx_word <= rx_en ? spf_pkg::spf_word_t'($random(seed)) : ~rx_word;
		end
		tx_ready <= tx_en && (($random(seed) & 1) != 0);
	end
endmodule : spf_shifter_model

// File: verif/spf_fifo_access_tb.sv
// self-checking bench for the serial port fifo access block
module spf_fifo_access_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic               clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic               rx_en = 1'b0, tx_en = 1'b0, ack, rxv, rxr, txv, txr, fm;
	logic [7:0]         adr = 8'h00;
	logic [3:0]         sel = 4'h0;
	logic [31:0]        dat = 32'h0, dato, q, w;
	logic [15:0]        txc, rxc, up;
	spf_pkg::spf_word_t rxw, txw;
	logic [31:0]        txq[$];
	integer             seed = 32'h38ba7e14;
	int                 error_cnt = 0, samples_checked = 0, i, n, t;

	// 200 MHz clock
	always #2.5 clk = ~clk;

	spf_fifo_access u_spf_fifo_access (.REF_CLK(clk), .RST_N(rst_n), .CYC_I(cyc), .STB_I(stb),
		.WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dato), .ACK_O(ack),
		.RX_VALID(rxv), .RX_WORD(rxw), .RX_READY(rxr), .TX_VALID(txv), .TX_WORD(txw),
		.TX_READY(txr), .FIFO_MODE(fm), .TX_FIFO_CTRL(txc), .RX_FIFO_CTRL(rxc));
	spf_shifter_model u_spf_shifter_model (.clk(clk), .rst_n(rst_n), .rx_en(rx_en),
		.tx_en(tx_en), .rx_valid(rxv), .rx_word(rxw), .rx_ready(rxr), .tx_valid(txv),
		.tx_word(txw), .tx_ready(txr));

	// verdict and end of run
	task automatic results();
		$display("checked %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results

	// compare one 16-bit result
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	// one classic bus cycle, held until ack is sampled
	task automatic wb(input logic wen, input logic [5:0] x, input logic [31:0] d);
		t = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wen;
		sel <= 4'hf;
		adr <= {x, 2'b00};
		dat <= d;
		do
		begin
			@(posedge clk);
			t++;
		end
		while (ack !== 1'b1 && t < 20);
		q = dato;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (t >= 20)
		begin
			error_cnt++;
			results();
		end
	endtask : wb

	task automatic rd(input logic [5:0] x);
		wb(1'b0, x, 32'h0);
	endtask : rd

	task automatic wr(input logic [5:0] x, input logic [15:0] d);
		wb(1'b1, x, {16'h0, d});
	endtask : wr

	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		// control registers: hidden outside fifo mode, reset values, read back
		rd(6'h20);
		chk("tx ctrl hidden", 16'h0, q[15:0]);
		wr(6'h20, 16'h1234);
		wr(6'h30, 16'h1);
		rd(6'h20);
		chk("tx ctrl reset", 16'ha000, q[15:0]);
		chk("tx ctrl port", 16'ha000, txc);
		rd(6'h21);
		chk("rx ctrl reset", 16'h201f, q[15:0]);
		for (i = 0; i < 2; i++)
		begin
			up = $random(seed);
			wr({5'h10, i[0]}, up);
			rd({5'h10, i[0]});
			chk("ctrl readback", up, q[15:0]);
			chk("ctrl port", up, i[0] ? rxc : txc);
		end
		rd(6'h3f);
		chk("unmapped", 16'h0, q[15:0]);
		$display("test registers done");
		// fill the receive fifo until it refuses, then read upper twice and lower once
		rx_en <= 1'b1;
		n = 0;
		do
		begin
			rd(6'h31);
			n++;
		end
		while (q[4:0] != 5'h10 && n < 200);
		rx_en <= 1'b0;
		if (n >= 200)
		begin
			error_cnt++;
			results();
		end
		rd(6'h00);
		rd(6'h00);
		rd(6'h31);
		chk("rx count", 16'h10, {11'h0, q[4:0]});
		for (i = 0; i < u_spf_shifter_model.rx_sent.size(); i++)
		begin
			w = u_spf_shifter_model.rx_sent[i];
			rd(6'h00);
			chk("rx upper", w[31:16], q[15:0]);
			rd(6'h00);
			chk("rx upper again", w[31:16], q[15:0]);
			rd(6'h01);
			chk("rx lower", w[15:0], q[15:0]);
		end
		rd(6'h31);
		chk("rx drained", 16'h0, {11'h0, q[4:0]});
		rd(6'h00);
		chk("rx empty read", 16'h0, q[15:0]);
		$display("test receive done");
		// fill transmit fifo and buffer with the shifter stalled, one word too many
		for (i = 0; i < 19; i++)
		begin
			w = $random(seed);
			if (i == 0)
				wr(6'h02, ~w[31:16]);
			wr(6'h02, w[31:16]);
			if (i == 3)
			begin
				rd(6'h31);
				chk("tx count upper", 16'h1, {11'h0, q[12:8]});
			end
			wr(6'h03, w[15:0]);
			if (i < 18)
				txq.push_back(w);
		end
		rd(6'h31);
		chk("tx count full", 16'h10, {11'h0, q[12:8]});
		chk("tx full", 16'h1, {15'h0, q[17]});
		chk("tx drop", 16'h1, {15'h0, q[19]});
		tx_en <= 1'b1;
		n = 0;
		while (u_spf_shifter_model.tx_got.size() < 18 && n < 2000)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 2000)
		begin
			error_cnt++;
			results();
		end
		for (i = 0; i < 18; i++)
		begin
			w = u_spf_shifter_model.tx_got[i];
			chk("tx upper", txq[i][31:16], w[31:16]);
			chk("tx lower", txq[i][15:0], w[15:0]);
		end
		$display("test transmit done");
		// plain mode: holding word and direct transmit on the same windows
		wr(6'h30, 16'h0);
		chk("mode port", 16'h0, {15'h0, fm});
		rx_en <= 1'b1;
		@(posedge clk);
		rx_en <= 1'b0;
		rd(6'h31);
		chk("rx held", 16'h1, {15'h0, q[22]});
		w = u_spf_shifter_model.rx_sent[u_spf_shifter_model.rx_sent.size() - 1];
		rd(6'h00);
		chk("plain rx upper", w[31:16], q[15:0]);
		rd(6'h01);
		chk("plain rx lower", w[15:0], q[15:0]);
		rd(6'h31);
		chk("rx held clear", 16'h0, {15'h0, q[22]});
		w = $random(seed);
		wr(6'h02, w[31:16]);
		wr(6'h03, w[15:0]);
		n = 0;
		while (u_spf_shifter_model.tx_got.size() < 19 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 200)
		begin
			error_cnt++;
			results();
		end
		q = u_spf_shifter_model.tx_got[18];
		chk("plain tx upper", w[31:16], q[31:16]);
		chk("plain tx lower", w[15:0], q[15:0]);
		$display("test plain mode done");
		results();
	end
endmodule : spf_fifo_access_tb
